// file: mcl_top.sv
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module mcl_top
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // device pins
    input wire logic clk_pin,
    input wire logic oe_n_pin,
    input wire logic [mcl_pkg::NIN-1:0] in_pin,
    input wire logic [mcl_pkg::NCELL-1:0] io_in,
    output logic [mcl_pkg::NCELL-1:0] io_out,
    output logic [mcl_pkg::NCELL-1:0] io_oe
);
    import mcl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    logic [NSYNC-1:0] lvl;
    logic [NCELL-1:0] io_lvl;
    logic [NIN-1:0] in_lvl;
    logic oe_n_lvl;
    logic clk_lvl;
    logic clk_prev_q;
    logic clk_rise;

    logic rag_q;
    logic fsg_q;
    logic [NCELL-1:0] mode_q;
    logic [NCELL-1:0] pol_q;
    logic prog_q;
    logic secure_q;
    logic [63:0] sig_q;
    logic [NCOL-1:0] fuse_q [NROW];

    logic act_q;
    logic wr_q;
    logic ok_q;
    logic [9:0] word_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic xfer;
    logic [31:0] rdata_d;

    logic w_cfg;
    logic w_prog;
    logic w_sig_lo;
    logic w_sig_hi;
    logic w_arr;
    logic do_erase;
    logic do_secure;
    logic do_preload;

    mcl_cfg_t cfg [NCELL];
    logic [NCELL-1:0] fb;
    logic [NCELL-1:0] fb_ok;
    logic [NCOL-1:0] lit;
    logic [NCELL-1:0] sop8;
    logic [NCELL-1:0] sop7;
    logic [NCELL-1:0] pt_oe;
    logic [NCELL-1:0] xo;
    logic [NCELL-1:0] oe_d;
    logic [NCELL-1:0] q_q;
    logic [NCELL-1:0] io_out_q;
    logic [NCELL-1:0] io_oe_q;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic in_array(input logic [9:0] w);
        return w[9:6] == ARRAY_PAGE;
    endfunction

    function automatic logic is_pair(input int i);
        return (i == PAIR_LO) || (i == PAIR_HI);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pins

    mcl_pin_sync u_sync
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_raw({clk_pin, oe_n_pin, in_pin, io_in}),
        .pin_lvl(lvl)
    );

    assign io_lvl = lvl[NCELL-1:0];
    assign in_lvl = lvl[NCELL +: NIN];
    assign oe_n_lvl = lvl[SY_OE];
    assign clk_lvl = lvl[SY_CLK];
    assign clk_rise = clk_lvl & ~clk_prev_q;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clk_prev_q <= 1'b0;
        end
        else
        begin
            clk_prev_q <= clk_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus address phase

    assign xfer = hsel & htrans[1] & hready;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            act_q <= 1'b0;
            wr_q <= 1'b0;
            ok_q <= 1'b0;
            word_q <= '0;
        end
        else
        begin
            act_q <= xfer;
            wr_q <= xfer & hwrite;
            ok_q <= haddr[31:12] == '0;
            word_q <= haddr[11:2];
        end
    end

    // read data is fetched at the address phase so the answer has no wait state
    always_comb
    begin
        rdata_d = '0;
        if (xfer && !hwrite && haddr[31:12] == '0)
        begin
            if (in_array(haddr[11:2]))
            begin
                if (!secure_q)
                begin
                    rdata_d = fuse_q[haddr[7:2]];
                end
            end
            else if (haddr[11:2] == W_CONFIG)
            begin
                rdata_d[CFG_RAG] = rag_q;
                rdata_d[CFG_FSG] = fsg_q;
                rdata_d[CFG_MODE +: NCELL] = mode_q;
                rdata_d[CFG_POL +: NCELL] = pol_q;
            end
            else if (haddr[11:2] == W_PROG)
            begin
                rdata_d[PROG_EN] = prog_q;
                rdata_d[PROG_SECURE] = secure_q;
            end
            else if (haddr[11:2] == W_SIG_LO)
            begin
                rdata_d = sig_q[31:0];
            end
            else if (haddr[11:2] == W_SIG_HI)
            begin
                rdata_d = sig_q[63:32];
            end
            else if (haddr[11:2] == W_STATUS)
            begin
                rdata_d[ST_Q +: NCELL] = q_q;
                rdata_d[ST_OUT +: NCELL] = io_out_q;
                rdata_d[ST_OE +: NCELL] = io_oe_q;
                rdata_d[ST_PROG] = prog_q;
                rdata_d[ST_SEC] = secure_q;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hrdata_q <= '0;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
        else
        begin
            hrdata_q <= rdata_d;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus data phase writes

    always_comb
    begin
        w_cfg = act_q & wr_q & ok_q & (word_q == W_CONFIG);
        w_prog = act_q & wr_q & ok_q & (word_q == W_PROG);
        w_sig_lo = act_q & wr_q & ok_q & (word_q == W_SIG_LO);
        w_sig_hi = act_q & wr_q & ok_q & (word_q == W_SIG_HI);
        w_arr = act_q & wr_q & ok_q & in_array(word_q);
        do_erase = w_prog & prog_q & hwdata[PROG_ERASE];
        do_secure = w_prog & prog_q & hwdata[PROG_SECURE];
        do_preload = w_prog & prog_q & hwdata[PROG_PRELOAD];
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prog_q <= 1'b0;
        end
        else if (w_prog)
        begin
            prog_q <= hwdata[PROG_EN];
        end
    end

    // the secure set wins when an erase comes in the same write
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            secure_q <= 1'b0;
        end
        else if (do_secure)
        begin
            secure_q <= 1'b1;
        end
        else if (do_erase)
        begin
            secure_q <= 1'b0;
        end
    end

    // configuration moves only while programming is open
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rag_q <= RAG_RST;
            fsg_q <= FSG_RST;
            mode_q <= MODE_RST;
            pol_q <= POL_RST;
        end
        else if (do_erase)
        begin
            rag_q <= RAG_RST;
            fsg_q <= FSG_RST;
            mode_q <= MODE_RST;
            pol_q <= POL_RST;
        end
        else if (w_cfg && prog_q)
        begin
            rag_q <= hwdata[CFG_RAG];
            fsg_q <= hwdata[CFG_FSG];
            mode_q <= hwdata[CFG_MODE +: NCELL];
            pol_q <= hwdata[CFG_POL +: NCELL];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sig_q <= '0;
        end
        else if (do_erase)
        begin
            sig_q <= '0;
        end
        else if (prog_q && w_sig_lo)
        begin
            sig_q[31:0] <= hwdata;
        end
        else if (prog_q && w_sig_hi)
        begin
            sig_q[63:32] <= hwdata;
        end
    end

    // blank array: nothing connected
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int r = 0; r < NROW; r++)
            begin
                fuse_q[r] <= '0;
            end
        end
        else if (do_erase)
        begin
            for (int r = 0; r < NROW; r++)
            begin
                fuse_q[r] <= '0;
            end
        end
        else if (w_arr && prog_q)
        begin
            fuse_q[word_q[5:0]] <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // feedback selection

    always_comb
    begin
        fb = '0;
        fb_ok = '0;
        for (int i = 0; i < NCELL; i++)
        begin
            cfg[i] = mcl_cell_cfg(rag_q, fsg_q, mode_q[i]);
            unique case (cfg[i])
                CFG_REG:
                begin
                    fb[i] = ~q_q[i];
                    fb_ok[i] = 1'b1;
                end
                CFG_CIO:
                begin
                    fb[i] = io_lvl[i];
                    fb_ok[i] = 1'b1;
                end
                CFG_COUT:
                begin
                    fb[i] = io_lvl[i];
                    fb_ok[i] = !is_pair(i);
                end
                CFG_DIN:
                begin
                    fb[i] = io_lvl[3'(i + 1)];
                    fb_ok[i] = 1'b1;
                end
                default:
                begin
                    fb_ok[i] = 1'b0;
                end
            endcase
        end
        // no registers: the enable and clock pins take over the end cells
        if (rag_q)
        begin
            fb[0] = oe_n_lvl;
            fb_ok[0] = 1'b1;
            fb[NCELL-1] = clk_lvl;
            fb_ok[NCELL-1] = 1'b1;
        end
    end

    // a missing feedback leaves both literals high, so it never kills a term
    always_comb
    begin
        lit = '0;
        for (int k = 0; k < NIN; k++)
        begin
            lit[2*k] = in_lvl[k];
            lit[2*k+1] = ~in_lvl[k];
        end
        for (int k = 0; k < NCELL; k++)
        begin
            lit[2*(NIN+k)] = fb[k] | ~fb_ok[k];
            lit[2*(NIN+k)+1] = ~fb[k] | ~fb_ok[k];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // product terms

    genvar gi;
    generate
        for (gi = 0; gi < NCELL; gi++)
        begin : g_cell
            logic [NTERM*NCOL-1:0] rows;

            always_comb
            begin
                rows = '0;
                for (int t = 0; t < NTERM; t++)
                begin
                    rows[t*NCOL +: NCOL] = fuse_q[gi*NTERM+t];
                end
            end

            mcl_sop u_sop
            (
                .fuse(rows),
                .lit(lit),
                .sop8(sop8[gi]),
                .sop7(sop7[gi]),
                .term_oe(pt_oe[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // macrocell output and enable

    always_comb
    begin
        xo = '0;
        oe_d = '0;
        for (int i = 0; i < NCELL; i++)
        begin
            unique case (cfg[i])
                CFG_CIO:
                begin
                    xo[i] = pol_q[i] ? sop7[i] : ~sop7[i];
                    oe_d[i] = pt_oe[i];
                end
                CFG_REG:
                begin
                    xo[i] = pol_q[i] ? sop8[i] : ~sop8[i];
                    oe_d[i] = ~oe_n_lvl;
                end
                CFG_COUT:
                begin
                    xo[i] = pol_q[i] ? sop8[i] : ~sop8[i];
                    oe_d[i] = 1'b1;
                end
                default:
                begin
                    xo[i] = 1'b0;
                    oe_d[i] = 1'b0;
                end
            endcase
        end
    end

    // cell flip-flops: preload beats the clock pin
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q_q <= '0;
        end
        else if (do_preload)
        begin
            q_q <= ~io_lvl;
        end
        else if (clk_rise && !prog_q)
        begin
            q_q <= ~xo;
        end
    end

    // outputs stay off while programming, as the cell wiring may be half written
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            io_out_q <= OUT_RST;
            io_oe_q <= '0;
        end
        else
        begin
            for (int i = 0; i < NCELL; i++)
            begin
                io_out_q[i] <= (cfg[i] == CFG_REG) ? ~q_q[i] : xo[i];
                io_oe_q[i] <= oe_d[i] & ~prog_q;
            end
        end
    end

    assign io_out = io_out_q;
    assign io_oe = io_oe_q;
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
endmodule

// file: mcl_pkg.sv
// What this block does
// - registers off, family on, cell mode 1: seven terms summed, eighth enables output
// - non-registered combinatorial i/o feeds the pin level back into the array, except the end cells when registers are off
// - without registers, clock pin and enable pin become inputs via last/first cell
// - registers on, family on, cell mode 1: combinatorial, term eight enables, pin feedback
// - registers off, family off, cell mode 1: dedicated input, output always off
// - dedicated input: inner cells read the adjacent pin, end cells read enable/clock
// - combinatorial output mode: the designated pin pair gives no array feedback
// - polarity bit drives an xor after the sum: 1 active high, 0 active low
// - power-up clears every cell flip-flop to low
// - registered outputs drive high after power-up through the inverting path
// - combinatorial outputs simply follow their logic after power-up
// - registers can be preloaded with any state from the pins, no clocking needed
// - once secured, array readback returns nothing useful
// - the secure bit clears only together with an array erase
// - a 64-bit user signature is held
// - the signature stays readable whatever the secure bit says
// - registered mode: capture on clock rise, inverted q feeds back, pin enable gates buffer
// - registers off, family off, cell mode 0: dedicated output summing all eight terms
// - empty term is high; a term with both polarities of one input is low
package mcl_pkg;
    localparam int unsigned NCELL = 8;
    localparam int unsigned NIN = 8;
    localparam int unsigned NTERM = 8;
    localparam int unsigned NCOL = 32;
    localparam int unsigned NROW = 64;
    localparam int unsigned NSYNC = 18;
    localparam int unsigned SY_OE = 16;
    localparam int unsigned SY_CLK = 17;
    localparam int unsigned OE_TERM = 7;
    localparam int unsigned PAIR_LO = 3;
    localparam int unsigned PAIR_HI = 4;
    // word index = haddr[11:2]
    localparam logic [9:0] W_CONFIG = 10'h000;
    localparam logic [9:0] W_PROG = 10'h001;
    localparam logic [9:0] W_SIG_LO = 10'h002;
    localparam logic [9:0] W_SIG_HI = 10'h003;
    localparam logic [9:0] W_STATUS = 10'h004;
    localparam logic [3:0] ARRAY_PAGE = 4'h1;
    localparam int unsigned CFG_RAG = 0;
    localparam int unsigned CFG_FSG = 1;
    localparam int unsigned CFG_MODE = 8;
    localparam int unsigned CFG_POL = 16;
    localparam int unsigned PROG_EN = 0;
    localparam int unsigned PROG_ERASE = 1;
    localparam int unsigned PROG_SECURE = 2;
    localparam int unsigned PROG_PRELOAD = 3;
    localparam int unsigned ST_Q = 0;
    localparam int unsigned ST_OUT = 8;
    localparam int unsigned ST_OE = 16;
    localparam int unsigned ST_PROG = 24;
    localparam int unsigned ST_SEC = 25;
    localparam logic RAG_RST = 1'b1;
    localparam logic FSG_RST = 1'b0;
    localparam logic [7:0] MODE_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [17:0] SYNC_RST = 18'h1_0000;

    typedef enum logic [2:0] {
        CFG_DIN = 3'b000,
        CFG_COUT = 3'b001,
        CFG_CIO = 3'b011,
        CFG_REG = 3'b010,
        CFG_BAD = 3'b110
    } mcl_cfg_t;

    function automatic mcl_cfg_t mcl_cell_cfg(input logic rag, input logic fsg, input logic md);
        unique case ({rag, fsg, md})
            3'b010: return CFG_REG;
            3'b011: return CFG_CIO;
            3'b111: return CFG_CIO;
            3'b100: return CFG_COUT;
            3'b101: return CFG_DIN;
            default: return CFG_BAD;
        endcase
    endfunction
endpackage

// file: mcl_pin_sync.sv
`timescale 1ns/10ps
module mcl_pin_sync
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // raw pins and filtered levels
    input wire logic [mcl_pkg::NSYNC-1:0] pin_raw,
    output logic [mcl_pkg::NSYNC-1:0] pin_lvl
);
    import mcl_pkg::*;

    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] lvl_q;

    // first stage feeds only the second
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            s3_q <= SYNC_RST;
            lvl_q <= SYNC_RST;
        end
        else
        begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a change counts once two later stages agree
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
        end
    end

    assign pin_lvl = lvl_q;
endmodule

// file: mcl_sop.sv
`timescale 1ns/10ps
module mcl_sop
(
    // fuse rows of one cell, connected = 1
    input wire logic [mcl_pkg::NTERM*mcl_pkg::NCOL-1:0] fuse,
    // true/complement literals
    input wire logic [mcl_pkg::NCOL-1:0] lit,
    // sums and enable term
    output logic sop8,
    output logic sop7,
    output logic term_oe
);
    import mcl_pkg::*;

    logic [NTERM-1:0] term;

    // unconnected literals read as one, so an empty term stays high
    always_comb
    begin
        term = '0;
        for (int t = 0; t < NTERM; t++)
        begin
            term[t] = &(~fuse[t*NCOL +: NCOL] | lit);
        end
    end

    assign sop8 = |term;
    assign sop7 = |term[OE_TERM-1:0];
    assign term_oe = term[OE_TERM];
endmodule

// file: mcl_top_properties.sv
`timescale 1ns/10ps
module mcl_top_properties
import mcl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // pins
    input wire logic oe_n_pin,
    input wire logic [mcl_pkg::NCELL-1:0] io_out,
    input wire logic [mcl_pkg::NCELL-1:0] io_oe
);
    localparam logic [31:0] CFG_INIT = {8'h00, POL_RST, MODE_RST, 6'h00, FSG_RST, RAG_RST};
    logic dp_q, dw_q, pen_q, sec_q, rd_now, wr_prog;
    logic [11:0] da_q;
    logic [31:0] cfg_q, sig_q;
    logic [7:0] din_m, cout_m, reg_m;
    ////////////////////////////////////////////////////////////////
    // shadow of what software set, so each output can be judged by its mode
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dp_q <= 1'b0;
            dw_q <= 1'b0;
            da_q <= 12'h000;
        end
        else
        begin
            dp_q <= hsel && htrans[1] && hready && haddr[31:12] == 20'h00000;
            dw_q <= hwrite;
            da_q <= haddr[11:0];
        end
    end
    assign wr_prog = dp_q && dw_q && da_q[11:2] == W_PROG;
    // secure wins over erase in one write, as the design does
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pen_q <= 1'b0;
            sec_q <= 1'b0;
            cfg_q <= CFG_INIT;
            sig_q <= 32'h0;
        end
        else
        begin
            if (wr_prog)
                pen_q <= hwdata[PROG_EN];
            if (wr_prog && pen_q && hwdata[PROG_SECURE])
                sec_q <= 1'b1;
            else if (wr_prog && pen_q && hwdata[PROG_ERASE])
                sec_q <= 1'b0;
            // erase still wipes config and signature when secure comes with it
            if (wr_prog && pen_q && hwdata[PROG_ERASE])
            begin
                cfg_q <= CFG_INIT;
                sig_q <= 32'h0;
            end
            if (dp_q && dw_q && pen_q && da_q[11:2] == W_CONFIG)
                cfg_q <= hwdata;
            if (dp_q && dw_q && pen_q && da_q[11:2] == W_SIG_LO)
                sig_q <= hwdata;
        end
    end
    assign din_m = cfg_q[15:8] & {8{cfg_q[CFG_RAG] & !cfg_q[CFG_FSG]}};
    assign cout_m = ~cfg_q[15:8] & {8{cfg_q[CFG_RAG] & !cfg_q[CFG_FSG]}};
    assign reg_m = ~cfg_q[15:8] & {8{!cfg_q[CFG_RAG] & cfg_q[CFG_FSG]}};
    assign rd_now = dp_q && !dw_q;
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_POWER_UP: assert property (
        $rose(reset_n) |-> io_out == 8'hff && io_oe == 8'h00) else $error("bad outputs at reset");
    AST_PROG_QUIET: assert property (
        pen_q && $past(pen_q) |-> io_oe == 8'h00) else $error("pins driven while programming");
    AST_DIN_OFF: assert property (
        !pen_q && !$past(pen_q) |-> (io_oe & din_m) == 8'h00) else $error("input cell drives");
    AST_COUT_ON: assert property (
        !pen_q && !$past(pen_q) |-> (io_oe & cout_m) == cout_m) else $error("output cell off");
    // the pin filter needs up to five edges, so the pin must have held for seven
    AST_REG_OE_OFF: assert property (
        (!pen_q && oe_n_pin) [*7] |-> (io_oe & reg_m) == 8'h00) else $error("oe pin ignored");
    AST_REG_OE_ON: assert property (
        (!pen_q && !oe_n_pin) [*7] |-> (io_oe & reg_m) == reg_m) else $error("oe pin ignored");
    // read data is fetched at the address edge, so it shows the state sampled there
    AST_SIG_READ: assert property (
        rd_now && da_q[11:2] == W_SIG_LO |-> hrdata == $past(sig_q))
        else $error("signature lost");
    AST_ARRAY_HIDDEN: assert property (
        rd_now && da_q[11:8] == ARRAY_PAGE && $past(sec_q) |-> hrdata == 32'h0)
        else $error("array seen");
    AST_SEC_STATUS: assert property (
        rd_now && da_q[11:2] == W_STATUS
        |-> hrdata[ST_SEC] == $past(sec_q) && hrdata[ST_PROG] == $past(pen_q))
        else $error("secure state wrong");
endmodule
bind mcl_top mcl_top_properties u_props (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .oe_n_pin(oe_n_pin), .io_out(io_out), .io_oe(io_oe));

// file: mcl_board.sv
`timescale 1ns/10ps
module mcl_board
(
    // level the board holds on each cell pin
    input wire logic [mcl_pkg::NCELL-1:0] level,
    // device side of the cell pins
    input wire logic [mcl_pkg::NCELL-1:0] io_out,
    input wire logic [mcl_pkg::NCELL-1:0] io_oe,
    output logic [mcl_pkg::NCELL-1:0] io_in
);
    import mcl_pkg::*;
    // a pin the device releases is held by the test controller, so preload sees its level
    assign io_in = (io_oe & io_out) | (~io_oe & level);
endmodule

// file: macrocell_config_logic_bench.sv
`timescale 1ns/10ps
module macrocell_config_logic_bench;
    import mcl_pkg::*;
    logic core_clk, reset_n, hsel, hwrite, hreadyout, hresp, clk_pin, oe_n_pin, rd_ph;
    logic [31:0] haddr, hwdata, hrdata, sig, em, mm;
    logic [1:0] htrans;
    logic [7:0] in_pin, level, io_in, io_out, io_oe, pol, v;
    logic [31:0] exp_q[$], msk_q[$];
    int bad_count = 0;
    int tests_run = 0;
    logic [15:0] cfg_tab [4] = '{16'h0001, 16'hff03, 16'hff02, 16'hff01};
    logic [7:0] oe_tab [4] = '{8'hff, 8'hdb, 8'hdb, 8'h00};
    logic [7:0] om_tab [4] = '{8'hff, 8'hff, 8'hff, 8'h00};
    mcl_top DUT (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .clk_pin(clk_pin),
        .oe_n_pin(oe_n_pin), .in_pin(in_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
    mcl_board u_board (.level(level), .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
    ////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // single transfer, address phase then data phase, both held until hready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= a;
        htrans <= 2'b10;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    // read data is judged at the edge that closes its data phase
    always @(posedge core_clk)
    begin
        if (rd_ph === 1'b1 && hreadyout === 1'b1)
        begin
            em = exp_q.pop_front();
            mm = msk_q.pop_front();
            tests_run++;
            if ((hrdata & mm) !== (em & mm) || hresp !== 1'b0)
            begin
                bad_count++;
                $display("mismatch at %0t: read %h expected %h mask %h", $time, hrdata, em, mm);
            end
        end
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        reset_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwdata = 32'h0;
        clk_pin = 1'b0;
        oe_n_pin = 1'b1;
        in_pin = 8'h00;
        level = 8'h00;
        rd_ph = 1'b0;
        void'($urandom(44434));
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        in_pin <= 8'($urandom());
        rd(32'h010, 32'h0, 32'h03ff_00ff);
        rd(32'h0000_2000, 32'h0, '1);
        wr(32'h004, 32'h1);
        sig = $urandom();
        wr(32'h008, sig);
        rd(32'h008, sig, '1);
        wr(32'h00c, ~sig);
        rd(32'h00c, ~sig, '1);
        wr(32'h100, ~sig);
        rd(32'h100, ~sig, '1);
        wr(32'h004, 32'h5);
        rd(32'h100, 32'h0, '1);
        rd(32'h008, sig, '1);
        rd(32'h010, 32'h0300_0000, 32'h0300_0000);
        wr(32'h004, 32'h3);
        rd(32'h010, 32'h0100_0000, 32'h0300_0000);
        rd(32'h100, 32'h0, '1);
        rd(32'h00c, 32'h0, '1);
        // secure and erase in one write: the set wins
        wr(32'h004, 32'h7);
        rd(32'h010, 32'h0300_0000, 32'h0300_0000);
        // cell 2 gets contradicting terms everywhere, cell 5 only on its enable term
        for (int i = 16; i < 24; i++)
            wr(32'h100 + 32'(4 * i), 32'h3);
        wr(32'h100 + 32'(4 * 47), 32'h3);
        pol = 8'($urandom());
        for (int k = 0; k < 4; k++)
        begin
            wr(32'h004, 32'h1);
            wr(32'h000, {8'h00, pol, cfg_tab[k]});
            wr(32'h004, 32'h0);
            idle(8);
            rd(32'h010, {8'h00, oe_tab[k], pol ^ 8'h04, 8'h00},
                {8'h00, 8'hff, om_tab[k], 8'h00});
            pol = ~pol;
        end
        v = 8'($urandom());
        level <= v;
        oe_n_pin <= 1'b0;
        wr(32'h004, 32'h1);
        wr(32'h000, {8'h00, pol, 16'h0002});
        idle(6);
        wr(32'h004, 32'h9);
        // io_out follows the preloaded flip-flop one edge later
        idle(1);
        rd(32'h010, {16'h0, v, ~v}, 32'h0000_ffff);
        wr(32'h004, 32'h0);
        idle(8);
        rd(32'h010, {8'h00, 8'hff, v, ~v}, 32'h00ff_ffff);
        oe_n_pin <= 1'b1;
        idle(8);
        rd(32'h010, 32'h0, 32'h00ff_0000);
        // device clock held long enough for the pin filter to count it
        clk_pin <= 1'b1;
        idle(6);
        clk_pin <= 1'b0;
        idle(6);
        rd(32'h010, {16'h0, pol ^ 8'h04, ~(pol ^ 8'h04)}, 32'h0000_ffff);
        stop_test();
    end
endmodule
